// *** hdl/isc_flag_cell.sv ***
// One sticky status flag with set-over-clear priority
`timescale 1ns/1ps
module isc_flag_cell
(
  // Clock and control
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Flag events
  input  wire logic set,
  input  wire logic clear,
  // Flag state
  output logic      flag
);

  // A source firing in the same cycle as a clear is kept
  always_ff @(posedge clk)
  begin
    if (reset)
      flag <= isc_pkg::FLAG_RESET;
    else if (ce)
    begin
      if (set)
        flag <= 1'b1;
      else if (clear)
        flag <= 1'b0;
    end
  end

endmodule

// *** hdl/isc_irq_control.sv ***
// Interrupt control, source enable mask, status flags and host interrupt output
`timescale 1ns/1ps
module isc_irq_control
#(
  parameter int PULSE_CYCLES = isc_pkg::EDGE_PULSE_CYCLES
)
(
  // Clock and control
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Byte register port from the serial slave
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Source events, one-cycle pulses
  input  wire logic       wake_event,
  input  wire logic       keypad_event,
  input  wire logic       keypad_overflow_event,
  input  wire logic       rotator_event,
  input  wire logic       rotator_overflow_event,
  input  wire logic       pwm0_event,
  input  wire logic       pwm1_event,
  input  wire logic       pwm2_event,
  input  wire logic       gpio_event,
  // Host interrupt
  output logic            irq_out
);

  logic [2:0] irq_control;
  logic [8:0] irq_source_enable_mask;
  logic [8:0] irq_status_flags;
  logic [8:0] src_vec;
  logic [8:0] stat_clear;
  logic       global_irq_gate;
  logic       irq_output_style;
  logic       irq_output_polarity;
  logic       pending;
  logic       pending_q;
  logic       edge_start;
  logic [7:0] pulse_cnt;
  logic       pulse_active;
  logic       next_active;

  assign global_irq_gate     = irq_control[isc_pkg::GATE_BIT];
  assign irq_output_style    = irq_control[isc_pkg::STYLE_BIT];
  assign irq_output_polarity = irq_control[isc_pkg::POL_BIT];

  // Source order in the flag and mask vectors
  assign src_vec[isc_pkg::SRC_WAKE]    = wake_event;
  assign src_vec[isc_pkg::SRC_KEYPAD]  = keypad_event;
  assign src_vec[isc_pkg::SRC_KEY_OVF] = keypad_overflow_event;
  assign src_vec[isc_pkg::SRC_ROTATOR] = rotator_event;
  assign src_vec[isc_pkg::SRC_ROT_OVF] = rotator_overflow_event;
  assign src_vec[isc_pkg::SRC_PWM0]    = pwm0_event;
  assign src_vec[isc_pkg::SRC_PWM1]    = pwm1_event;
  assign src_vec[isc_pkg::SRC_PWM2]    = pwm2_event;
  assign src_vec[isc_pkg::SRC_GPIO]    = gpio_event;

  // Control register; upper byte is read-only zero
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_control <= isc_pkg::CTRL_RESET;
    else if (ce && reg_wr && reg_addr == isc_pkg::ADDR_CTRL_LSB)
      irq_control <= reg_wdata[2:0];
  end

  // Enable mask; its own process so control writes never reach it
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_source_enable_mask <= isc_pkg::MASK_RESET;
    else if (ce && reg_wr && reg_addr == isc_pkg::ADDR_MASK_MSB)
      irq_source_enable_mask[8] <= reg_wdata[0];
    else if (ce && reg_wr && reg_addr == isc_pkg::ADDR_MASK_LSB)
      irq_source_enable_mask[7:0] <= reg_wdata;
  end

  // Write one to a status bit clears it
  always_comb
  begin
    stat_clear = 9'h000;
    if (reg_wr && reg_addr == isc_pkg::ADDR_STAT_MSB)
      stat_clear[8] = reg_wdata[0];
    else if (reg_wr && reg_addr == isc_pkg::ADDR_STAT_LSB)
      stat_clear[7:0] = reg_wdata;
  end

  // One sticky flag per source
  for (genvar i = 0; i < isc_pkg::NUM_SOURCES; i++)
  begin : g_flag
    isc_flag_cell u_cell
    (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .set   (src_vec[i]),
      .clear (stat_clear[i]),
      .flag  (irq_status_flags[i])
    );
  end

  // Registered read data, one cycle after the address; reserved bits read zero
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (ce)
    begin
      unique case (reg_addr)
        isc_pkg::ADDR_CTRL_LSB: reg_rdata <= {5'h00, irq_control};
        isc_pkg::ADDR_MASK_MSB: reg_rdata <= {7'h00, irq_source_enable_mask[8]};
        isc_pkg::ADDR_MASK_LSB: reg_rdata <= irq_source_enable_mask[7:0];
        isc_pkg::ADDR_STAT_MSB: reg_rdata <= {7'h00, irq_status_flags[8]};
        isc_pkg::ADDR_STAT_LSB: reg_rdata <= irq_status_flags[7:0];
        default:                reg_rdata <= 8'h00;
      endcase
    end
  end

  // Pending stays up while any enabled flag is set and the gate is open
  assign pending = global_irq_gate && |(irq_status_flags & irq_source_enable_mask);

  // Edge mode fires a fixed-width pulse on each new rise of pending
  assign edge_start   = irq_output_style && pending && !pending_q;
  assign pulse_active = pulse_cnt != 8'h00;

  // Last pending value, for spotting a new rise
  always_ff @(posedge clk)
  begin
    if (reset)
      pending_q <= 1'b0;
    else if (ce)
      pending_q <= pending;
  end

  // A new rise reloads the count; a later source while pending is still up starts no new pulse
  always_ff @(posedge clk)
  begin
    if (reset)
      pulse_cnt <= 8'h00;
    else if (ce)
    begin
      if (edge_start)
        pulse_cnt <= 8'(PULSE_CYCLES);
      else if (pulse_active)
        pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  // Level mode holds until the flag, its mask bit or the gate is cleared, so a host cannot miss it
  assign next_active = irq_output_style ? (edge_start || (pulse_active && pulse_cnt != 8'h01))
                                        : pending;

  // Output register; reset shows the inactive level of the reset polarity
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_out <= 1'b1;
    else if (ce)
      irq_out <= irq_output_polarity ? next_active : !next_active;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_edge_start;
    ce && edge_start;
  endsequence

  sequence s_pulse_loaded;
    pulse_cnt == 8'(PULSE_CYCLES);
  endsequence

  sequence s_pulse_last;
    ce && irq_output_style && pulse_cnt == 8'h01 && !edge_start;
  endsequence

  // Output checks look one edge on, as irq_out is registered
  gate_suppress_a: assert property (ce && !global_irq_gate && !pulse_active
      |=> irq_out == !$past(irq_output_polarity))
    else $error("interrupt driven while global gate is off");
  mask_hold_a: assert property (ce && reg_wr && reg_addr == isc_pkg::ADDR_CTRL_LSB
      |=> irq_source_enable_mask == $past(irq_source_enable_mask))
    else $error("control write changed the enable mask");
  edge_pulse_a: assert property (s_edge_start |=> s_pulse_loaded)
    else $error("edge pulse not started at full width");
  edge_end_a: assert property (s_pulse_last
      |=> irq_out == !$past(irq_output_polarity))
    else $error("edge pulse did not end after its count");
  level_idle_a: assert property (ce && !irq_output_style && !pending
      |=> irq_out == !$past(irq_output_polarity))
    else $error("idle level does not match polarity");
  mask_block_a: assert property (ce && !pulse_active
      && (irq_status_flags & irq_source_enable_mask) == 9'h000
      |=> irq_out == !$past(irq_output_polarity))
    else $error("interrupt driven with no enabled flag");
  // One map check per group; the other sources share the same vector
  keyovf_map_a: assert property (ce && keypad_overflow_event |=> irq_status_flags[2])
    else $error("keypad overflow not on bit 2");
  pwm1_map_a: assert property (ce && pwm1_event |=> irq_status_flags[6])
    else $error("pwm channel 1 not on bit 6");
  gpio_map_a: assert property (ce && gpio_event |=> irq_status_flags[8])
    else $error("gpio not on bit 8");
  level_hold_a: assert property (ce && !irq_output_style && pending
      |=> irq_out == $past(irq_output_polarity))
    else $error("level output dropped while pending");
  flag_set_a: assert property (ce && src_vec != 9'h000
      |=> (irq_status_flags & $past(src_vec)) == $past(src_vec))
    else $error("source event lost");
  any_pending_a: assert property (ce && global_irq_gate && !pending_q
      && (irq_status_flags & irq_source_enable_mask) != 9'h000
      |=> irq_out == $past(irq_output_polarity))
    else $error("enabled flag did not assert the interrupt");
  // A low clock enable must freeze flags and output alike
  ce_freeze_a: assert property (!ce
      |=> irq_status_flags == $past(irq_status_flags) && irq_out == $past(irq_out))
    else $error("state moved while the clock enable was low");

endmodule

// *** hdl/isc_pkg.sv ***
// Constants for the interrupt control and source enable block
// How it works
// - Control bit 0 gates all interrupts; zero suppresses every host interrupt except an edge pulse already running, which ends at its count.
// - Writing the gate bit leaves the source enable mask untouched.
// - Control bit 1 picks level (zero) or edge (one) output signalling.
// - Control bit 2 picks active low/falling (zero) or active high/rising (one).
// - Mask bits 8 to 0 let their source interrupt; bits 15 to 9 read zero.
// - Mask bits 0 to 4: wake-up, keypad, keypad overflow, rotator, rotator overflow.
// - Mask bits 5, 6 and 7 belong to PWM channels 0, 1 and 2.
// - Mask bit 8 gates the GPIO controller interrupt.
// - In level style an asserted output stays asserted until software clears the status flag, mask bit or gate bit; edge style gives a fixed-width pulse.
// - Status flags set when their source fires, whatever the mask says.
package isc_pkg;

  // Byte register addresses, most significant byte first
  localparam logic [7:0] ADDR_CTRL_MSB = 8'h10;
  localparam logic [7:0] ADDR_CTRL_LSB = 8'h11;
  localparam logic [7:0] ADDR_MASK_MSB = 8'h12;
  localparam logic [7:0] ADDR_MASK_LSB = 8'h13;
  localparam logic [7:0] ADDR_STAT_MSB = 8'h14;
  localparam logic [7:0] ADDR_STAT_LSB = 8'h15;

  // Control field positions
  localparam int GATE_BIT  = 0;
  localparam int STYLE_BIT = 1;
  localparam int POL_BIT   = 2;

  // Source indices
  localparam int NUM_SOURCES  = 9;
  localparam int SRC_WAKE     = 0;
  localparam int SRC_KEYPAD   = 1;
  localparam int SRC_KEY_OVF  = 2;
  localparam int SRC_ROTATOR  = 3;
  localparam int SRC_ROT_OVF  = 4;
  localparam int SRC_PWM0     = 5;
  localparam int SRC_PWM1     = 6;
  localparam int SRC_PWM2     = 7;
  localparam int SRC_GPIO     = 8;

  // Reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [8:0] MASK_RESET = 9'h000;
  localparam logic       FLAG_RESET = 1'b0;

  // Edge mode pulse width
  localparam int CLK_PERIOD_NS     = 40;
  localparam int EDGE_PULSE_NS     = 200;
  localparam int EDGE_PULSE_CYCLES = (EDGE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** verification/isc_host_model.sv ***
// Host model that watches the interrupt pin and measures each assertion
`timescale 1ns/1ps
module isc_host_model
(
  // Clock and pin
  input  wire logic clk,
  input  wire logic irq_pin,
  input  wire logic active_high,
  // What the host saw
  output int        n_assert,
  output int        last_width
);
  int   width = 0;
  logic was_active = 1'b0;
  initial n_assert = 0;
  initial last_width = 0;
  // The host only samples the pin on its clock, so widths are whole cycles
  always @(posedge clk)
  begin
    was_active <= (irq_pin == active_high);
    if ((irq_pin == active_high) && !was_active)
      n_assert <= n_assert + 1;
    if (irq_pin == active_high)
      width <= width + 1;
    else if (width != 0)
    begin
      last_width <= width;
      width <= 0;
    end
  end
endmodule

// *** verification/isc_irq_control_bench.sv ***
// Self-checking bench for the interrupt control and source enable block
`timescale 1ns/1ps
module isc_irq_control_bench;
  localparam int PULSE = 2;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [8:0] ev = 9'h000;
  logic       pol = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] reg_rdata;
  logic       irq_out;
  logic [8:0] m;
  int         n_assert, last_width, base, mismatches = 0, n_checks = 0, cycles = 0;

  always #20 clk = ~clk;

  isc_irq_control #(.PULSE_CYCLES(PULSE)) DUT (.clk(clk), .reset(reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .wake_event(ev[0]), .keypad_event(ev[1]), .keypad_overflow_event(ev[2]),
    .rotator_event(ev[3]), .rotator_overflow_event(ev[4]), .pwm0_event(ev[5]),
    .pwm1_event(ev[6]), .pwm2_event(ev[7]), .gpio_event(ev[8]), .irq_out(irq_out));

  isc_host_model HOST (.clk(clk), .irq_pin(irq_out), .active_high(pol),
    .n_assert(n_assert), .last_width(last_width));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One byte write; strobe drops at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data lands one edge after the address, so look half a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(negedge clk);
    check(reg_rdata, exp);
  endtask

  task automatic pulse(input int i, input int wait_cycles);
    @(posedge clk);
    ev <= 9'h001 << i;
    @(posedge clk);
    ev <= 9'h000;
    repeat (wait_cycles) @(posedge clk);
    @(negedge clk);
  endtask

  // Clear all flags; one more edge lets the registered output follow
  task automatic clr();
    wr(8'h14, 8'hff);
    wr(8'h15, 8'hff);
    @(posedge clk);
  endtask

  task automatic t_regs();
    for (int a = 16; a < 22; a++) rd(a[7:0], 8'h00);
    check(irq_out, 1'b1);
    wr(8'h12, 8'hff);
    wr(8'h13, 8'hff);
    rd(8'h12, 8'h01);
    wr(8'h11, 8'h01);
    wr(8'h10, 8'hff);
    rd(8'h13, 8'hff);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h01);
    $display("registers test done");
  endtask

  // Each source alone enabled; its neighbour fires too but stays masked
  task automatic t_map();
    wr(8'h11, 8'h05);
    pol <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      m = 9'h001 << i;
      wr(8'h12, {7'h00, m[8]});
      wr(8'h13, m[7:0]);
      pulse((i + 1) % 9, 2);
      check(irq_out, 1'b0);
      pulse(i, 6);
      check(irq_out, 1'b1);
      m = m | (9'h001 << ((i + 1) % 9));
      rd(8'h14, {7'h00, m[8]});
      rd(8'h15, m[7:0]);
      clr();
      @(negedge clk);
      check(irq_out, 1'b0);
    end
    $display("source map test done");
  endtask

  task automatic t_gate();
    wr(8'h12, 8'h01);
    wr(8'h13, 8'hff);
    wr(8'h11, 8'h00);
    pol <= 1'b0;
    pulse(2, 3);
    check(irq_out, 1'b1);
    wr(8'h11, 8'h01);
    @(posedge clk);
    @(negedge clk);
    check(irq_out, 1'b0);
    // A clear sent while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    clr();
    ce <= 1'b1;
    @(negedge clk);
    check(irq_out, 1'b0);
    clr();
    @(negedge clk);
    check(irq_out, 1'b1);
    $display("gate test done");
  endtask

  // Edge style in both polarities, counted and timed by the host model
  task automatic t_edge();
    for (int p = 0; p < 2; p++)
    begin
      wr(8'h11, p ? 8'h07 : 8'h03);
      pol <= p[0];
      repeat (3) @(posedge clk);
      base = n_assert;
      pulse(3, PULSE + 6);
      check(n_assert - base, 1);
      check(last_width, PULSE);
      check(irq_out, !p[0]);
      clr();
    end
    $display("edge test done");
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run needs under 1500 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_map();
    t_gate();
    t_edge();
    conclude();
  end
endmodule
